/* srmc_pkg.sv */
// srmc_pkg: constants and types for the static memory controller
// assumes a 20 MHz core clock and the slower speed grade timing
package srmc_pkg;
  localparam int ADDR_W = 13;
  localparam int DATA_W = 8;
  localparam int CLK_PERIOD_NS = 50;
  // least times, slower grade, in ns
  localparam int T_CYCLE_NS = 100;
  localparam int T_WP_NS = 60;
  localparam int T_AW_NS = 80;
  localparam int T_DW_NS = 40;
  localparam int T_WHZ_NS = 35;
  localparam int T_AA_NS = 100;
  localparam int T_OHZ_NS = 35;
  localparam int T_RECOVER_NS = 100;
  // counts, least times rounded up
  localparam int CYC_CYCLE = (T_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WP_RAW = (T_WP_NS > T_AW_NS) ? T_WP_NS : T_AW_NS;
  localparam int WP_OE_LOW = T_WHZ_NS + T_DW_NS;
  localparam int WP_NS = (WP_RAW > WP_OE_LOW) ? WP_RAW : WP_OE_LOW;
  localparam int CYC_WRITE = (WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYC_READ = (T_AA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYC_TURN = (T_OHZ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYC_RECOVER = (T_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
  localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_RST = 13'h0000;
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;

  typedef enum logic [2:0] {
    SRMC_IDLE = 3'b000,
    SRMC_RD = 3'b001,
    SRMC_WR = 3'b010,
    SRMC_GAP = 3'b011,
    SRMC_TURN = 3'b100,
    SRMC_RET = 3'b101,
    SRMC_WAKE = 3'b110
  } srmc_state_e;
endpackage

/* srmc_tick_if.sv */
// srmc_tick_if: load and expiry of the phase down counter
// assumes one clock domain shared by both ends
`timescale 1ns/1ns
interface srmc_tick_if;
  import srmc_pkg::*;
  logic load;
  logic [CNT_W-1:0] value;
  logic done;
  modport owner (output load, output value, input done);
  modport timer (input load, input value, output done);
endinterface

/* srmc_timer.sv */
// srmc_timer: phase down counter, done while at zero
// assumes load is a one-cycle request from the sequencer
`timescale 1ns/1ns
module srmc_timer
  import srmc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  srmc_tick_if.timer tick
);
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
  } srmc_tmr_s;
  srmc_tmr_s cur_ff;
  srmc_tmr_s nxt_cur;

  // reload wins over counting down
  always_comb begin
    nxt_cur = cur_ff;
    if (tick.load) begin
      nxt_cur.cnt = tick.value;
    end else if (cur_ff.cnt != CNT_ZERO) begin
      nxt_cur.cnt = cur_ff.cnt - CNT_ONE;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cur_ff <= '{cnt: CNT_ZERO};
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // done must not look at load: the sequencer loads on done, which would close a loop
  assign tick.done = (cur_ff.cnt == CNT_ZERO);
endmodule

/* srmc_ctrl.sv */
// srmc_ctrl: host controller for an 8k x 8 asynchronous static memory
// assumes memory pins are registered here and the board adds no skew
`timescale 1ns/1ns
module srmc_ctrl
  import srmc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [DATA_W-1:0] req_wdata,
  output logic req_ready,
  output logic [DATA_W-1:0] rsp_rdata,
  output logic rsp_valid,
  input wire logic retain_req,
  output logic retain_active,
  output logic [ADDR_W-1:0] word_address,
  output logic select_active_low_n,
  output logic select_active_high,
  output logic write_strobe_n,
  output logic output_enable_n,
  output logic [DATA_W-1:0] shared_data_bus_out,
  output logic shared_data_bus_oe_n,
  input wire logic [DATA_W-1:0] shared_data_bus_in
);
  typedef struct packed {
    srmc_state_e st;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    logic rvalid;
    logic sel;
    logic we;
    logic oe;
    logic drive;
  } srmc_ctl_s;

  srmc_ctl_s cur_ff;
  srmc_ctl_s nxt_cur;
  srmc_tick_if tick ();

  srmc_timer u_timer (
    .core_clk(core_clk),
    .rst(rst),
    .tick(tick.timer)
  );

  //////////////////////////////////////////////////////////////////////////////
  // sequencer: one access per phase, timer paces each phase
  always_comb begin
    nxt_cur = cur_ff;
    nxt_cur.rvalid = 1'b0;
    tick.load = 1'b0;
    tick.value = CNT_ZERO;
    case (cur_ff.st)
      SRMC_IDLE: begin
        if (retain_req) begin
          // deselect before supply drop, zero delay needed
          nxt_cur.sel = 1'b0;
          nxt_cur.st = SRMC_RET;
        end else if (req_valid) begin
          // address and data settle with the selects, window opens at once
          nxt_cur.addr = req_addr;
          nxt_cur.sel = 1'b1;
          tick.load = 1'b1;
          if (req_write) begin
            nxt_cur.wdata = req_wdata;
            nxt_cur.we = 1'b1;
            nxt_cur.drive = 1'b1;
            // oe stays high in writes, so the memory is never driving
            nxt_cur.oe = 1'b0;
            tick.value = CNT_W'(CYC_WRITE - 1);
            nxt_cur.st = SRMC_WR;
          end else begin
            nxt_cur.oe = 1'b1;
            tick.value = CNT_W'(CYC_READ - 1);
            nxt_cur.st = SRMC_RD;
          end
        end
      end
      SRMC_RD: begin
        if (tick.done) begin
          // sample after full access time, data still held on release
          nxt_cur.rdata = shared_data_bus_in;
          nxt_cur.rvalid = 1'b1;
          nxt_cur.oe = 1'b0;
          nxt_cur.sel = 1'b0;
          tick.load = 1'b1;
          tick.value = CNT_W'(CYC_TURN - 1);
          nxt_cur.st = SRMC_TURN;
        end
      end
      SRMC_WR: begin
        if (tick.done) begin
          // strobe ends window; address held, data bus released on this same edge
          nxt_cur.we = 1'b0;
          nxt_cur.sel = 1'b0;
          nxt_cur.drive = 1'b0;
          tick.load = 1'b1;
          tick.value = CNT_W'(CYC_CYCLE - 1);
          nxt_cur.st = SRMC_GAP;
        end
      end
      SRMC_TURN: begin
        // waits the bus release time only, one cycle; the read access already spans the cycle time
        if (tick.done) begin
          nxt_cur.st = SRMC_IDLE;
        end
      end
      SRMC_GAP: begin
        if (tick.done) begin
          nxt_cur.st = SRMC_IDLE;
        end
      end
      SRMC_RET: begin
        // selects held at firm levels, nothing driven on data
        if (!retain_req) begin
          tick.load = 1'b1;
          tick.value = CNT_W'(CYC_RECOVER - 1);
          nxt_cur.st = SRMC_WAKE;
        end
      end
      SRMC_WAKE: begin
        if (tick.done) begin
          nxt_cur.st = SRMC_IDLE;
        end
      end
      default: begin
        nxt_cur.st = SRMC_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cur_ff <= '{st: SRMC_IDLE, addr: ADDR_RST, wdata: DATA_RST, rdata: DATA_RST,
                  rvalid: 1'b0, sel: 1'b0, we: 1'b0, oe: 1'b0, drive: 1'b0};
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // pins straight from flops, so no glitches reach the memory
  assign word_address = cur_ff.addr;
  assign select_active_low_n = !cur_ff.sel;
  assign select_active_high = cur_ff.sel;
  assign write_strobe_n = !cur_ff.we;
  assign output_enable_n = !cur_ff.oe;
  assign shared_data_bus_out = cur_ff.wdata;
  assign shared_data_bus_oe_n = !cur_ff.drive;
  assign rsp_rdata = cur_ff.rdata;
  assign rsp_valid = cur_ff.rvalid;
  assign retain_active = (cur_ff.st == SRMC_RET);
  assign req_ready = (cur_ff.st == SRMC_IDLE) && !retain_req;
endmodule

/* srmc_mem_model.sv */
// srmc_mem_model: behavioural 8k x 8 static memory on the far side
// assumes pins come straight from the controller, no board skew
`timescale 1ns/1ns
module srmc_mem_model
  import srmc_pkg::*;
(
  input wire logic clk,
  input wire logic [ADDR_W-1:0] a,
  input wire logic cs_n,
  input wire logic cs,
  input wire logic we_n,
  input wire logic oe_n,
  input wire logic [DATA_W-1:0] dout,
  input wire logic doe_n,
  output logic [DATA_W-1:0] din
);
  logic [DATA_W-1:0] mem [0:8191];
  logic [DATA_W-1:0] last;
  logic sel;
  logic drv;
  // deselect ignores strobes and floats the pins
  assign sel = !cs_n && cs;
  assign drv = sel && we_n && !oe_n;
  ////////////////////////////////////////
  // store during overlap of both selects and a low strobe
  always @(posedge clk) begin
    if (sel && !we_n) mem[a] <= dout;
  end
  // wire level: clash is unknown, a floating bus keeps changing
  always_comb begin
    if (drv && !doe_n) din = 'x;
    else if (drv) din = mem[a];
    else if (!doe_n) din = dout;
    else din = ~last;
  end
  always @(posedge clk) last <= din;
endmodule

/* srmc_ctrl_assertions.sv */
// srmc_ctrl_assertions: pin timing checks on the memory controller
// assumes the design's top ports and one clock domain
`timescale 1ns/1ns
module srmc_ctrl_assertions
  import srmc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic req_ready,
  input wire logic [DATA_W-1:0] rsp_rdata,
  input wire logic rsp_valid,
  input wire logic retain_req,
  input wire logic retain_active,
  input wire logic [ADDR_W-1:0] word_address,
  input wire logic select_active_low_n,
  input wire logic select_active_high,
  input wire logic write_strobe_n,
  input wire logic output_enable_n,
  input wire logic shared_data_bus_oe_n,
  input wire logic [DATA_W-1:0] shared_data_bus_in
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  a_sel_pair: assert property (select_active_high == !select_active_low_n)
    else $error("selects disagree");
  a_wr_window: assert property ($fell(write_strobe_n) |->
    (!write_strobe_n && !select_active_low_n)[*2] ##1 write_strobe_n)
    else $error("write window width wrong");
  a_wr_addr: assert property (!write_strobe_n |=> $stable(word_address))
    else $error("address moved in write");
  a_wr_data: assert property (!write_strobe_n |-> !shared_data_bus_oe_n && output_enable_n)
    else $error("write data not driven");
  a_rd_pins: assert property (req_valid && req_ready && !req_write |->
    ##2 (!output_enable_n && write_strobe_n && shared_data_bus_oe_n))
    else $error("read pins wrong");
  a_rd_latency: assert property (req_valid && req_ready && !req_write |-> ##3 rsp_valid)
    else $error("read answer late");
  a_rd_data: assert property (rsp_valid |-> rsp_rdata == $past(shared_data_bus_in))
    else $error("read data not bus value");
  a_ret_desel: assert property (retain_active |-> select_active_low_n && !select_active_high)
    else $error("selected in retention");
  a_ret_refuse: assert property (retain_req |-> !req_ready)
    else $error("ready while retaining");
endmodule
bind srmc_ctrl srmc_ctrl_assertions u_chk (.core_clk, .rst, .req_valid, .req_write, .req_ready,
  .rsp_rdata, .rsp_valid, .retain_req, .retain_active, .word_address, .select_active_low_n,
  .select_active_high, .write_strobe_n, .output_enable_n, .shared_data_bus_oe_n, .shared_data_bus_in);

/* tb_top.sv */
// tb_top: self-checking bench for the memory controller
// assumes the behavioural memory model answers on the far side
`timescale 1ns/1ns
module tb_top;
  import srmc_pkg::*;
  logic core_clk = 0;
  logic rst = 1;
  logic req_valid = 0;
  logic req_write = 0;
  logic retain_req = 0;
  logic [ADDR_W-1:0] req_addr = '0;
  logic [DATA_W-1:0] req_wdata = '0;
  logic req_ready, rsp_valid, retain_active, cs_n, cs, we_n, oe_n, doe_n;
  logic [DATA_W-1:0] rsp_rdata, dout, din;
  logic [ADDR_W-1:0] a;
  int errors = 0;
  int n_compared = 0;
  always #25 core_clk = ~core_clk;
  srmc_ctrl u_dut (.core_clk, .rst, .req_valid, .req_write, .req_addr, .req_wdata, .req_ready,
    .rsp_rdata, .rsp_valid, .retain_req, .retain_active, .word_address(a), .select_active_low_n(cs_n),
    .select_active_high(cs), .write_strobe_n(we_n), .output_enable_n(oe_n), .shared_data_bus_out(dout),
    .shared_data_bus_oe_n(doe_n), .shared_data_bus_in(din));
  srmc_mem_model u_mem (.clk(core_clk), .a, .cs_n, .cs, .we_n, .oe_n, .dout, .doe_n, .din);
  ////////////////////////////////////////
  task finish_test;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task chk(string name, logic [12:0] seen, logic [12:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // one access; request held until taken, read judged on its answer
  task access(logic w, logic [12:0] ad, logic [7:0] d);
    int n;
    req_valid <= 1;
    req_write <= w;
    req_addr <= ad;
    req_wdata <= d;
    n = 0;
    do begin @(negedge core_clk); n++; end while (req_ready !== 1 && n < 40);
    if (req_ready !== 1) begin errors++; finish_test; end
    @(posedge core_clk);
    req_valid <= 0;
    if (!w) begin
      n = 0;
      do begin @(negedge core_clk); n++; end while (rsp_valid !== 1 && n < 10);
      chk("rd_lat", 13'(n), 13'(CYC_READ + 1));
      chk("rdata", 13'(rsp_rdata), 13'(d));
      // a read answer that never came ends the run here
      if (rsp_valid !== 1) finish_test;
    end
    @(posedge core_clk);
  endtask
  // corner addresses and values, write then read back to back
  task t_bounds;
    access(1, 13'h0000, 8'hff);
    access(1, 13'h1fff, 8'h00);
    access(0, 13'h0000, 8'hff);
    access(0, 13'h1fff, 8'h00);
  endtask
  // overwrite must not disturb the neighbour
  task t_overwrite;
    access(1, 13'h0aaa, 8'ha5);
    access(1, 13'h0aab, 8'h3c);
    access(1, 13'h0aaa, 8'h5a);
    access(0, 13'h0aab, 8'h3c);
    access(0, 13'h0aaa, 8'h5a);
  endtask
  // retention deselects and refuses; contents survive the wake
  task t_retain;
    retain_req <= 1;
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
    chk("ret_act", 13'(retain_active), 13'h1);
    chk("ret_sel", 13'({cs_n, cs}), 13'h2);
    chk("ret_rdy", 13'(req_ready), 13'h0);
    @(posedge core_clk);
    retain_req <= 0;
    @(posedge core_clk);
    @(negedge core_clk);
    chk("wake_rdy", 13'(req_ready), 13'h0);
    @(posedge core_clk);
    @(negedge core_clk);
    chk("wake_rdy2", 13'(req_ready), 13'h0);
    @(posedge core_clk);
    access(0, 13'h1fff, 8'h00);
  endtask
  initial begin
    repeat (8) @(posedge core_clk);
    chk("rst_pins", 13'({cs_n, cs, we_n, oe_n, doe_n}), 13'h17);
    rst <= 0;
    @(posedge core_clk);
    t_bounds;
    t_overwrite;
    t_retain;
    finish_test;
  end
endmodule
